// ===== core/pcg_map.svh
// field positions, reset values and timing counts of the gauge sequencer
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
`define PCG_CLK_PERIOD_NS   20
`define PCG_MEAS_PERIOD_MS  1000
`define PCG_MEAS_CYCLES     ((`PCG_MEAS_PERIOD_MS * 1000000) / `PCG_CLK_PERIOD_NS)
`define PCG_HEALTH_MAX      8'h64
`define PCG_COND_HLOW_BIT   0
`define PCG_COND_EOL_BIT    1
`define PCG_CTRL_ACT_BIT    0
`define PCG_CTRL_DONE_BIT   1
`define PCG_FLAGS_RST       8'h00
`define PCG_WORD_RST        16'h0000
`define PCG_CHARGE_RST      32'h0000_0000
`endif

// ===== core/pcg_pkg.sv
// types of the gauge sequencer
package pcg_pkg;
  typedef enum logic [1:0] {
    PCG_ACCUMULATE_MODE  = 2'h0,
    PCG_HEALTH_MODE      = 2'h1,
    PCG_END_OF_LIFE_MODE = 2'h2
  } pcg_mode_t;
  typedef enum logic [2:0] {
    PCG_OFF, PCG_ACC_WAIT, PCG_ACC_RUN, PCG_ACC_END, PCG_ACC_DONE, PCG_SOH_MEAS, PCG_SOH_DONE,
    PCG_EOL_RUN
  } pcg_state_t;
endpackage

// ===== core/pcg_sequencer.sv
// measurement and gauging sequencer for a primary-cell monitor
`timescale 1ns/1ps
`include "pcg_map.svh"
module pcg_sequencer
  import pcg_pkg::*;
#(
  parameter int unsigned MEAS_CYCLES = `PCG_MEAS_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               host_power_gate_pin_i,
  input  wire logic [1:0]         mode_cfg_i,
  input  wire logic               temp_source_select_i,
  input  wire logic               begin_accum_i,
  input  wire logic               end_accum_i,
  input  wire logic               meas_valid_i,
  input  wire logic [15:0]        cell_voltage_input_i,
  input  wire logic signed [15:0] die_temp_raw_i,
  input  wire logic signed [15:0] ext_temp_raw_i,
  input  wire logic               cc_valid_i,
  input  wire logic signed [14:0] cc_sample_i,
  input  wire logic signed [15:0] self_consumption_offset_i,
  input  wire logic               ext_scale_en_i,
  input  wire logic [7:0]         cell_gain_i,
  input  wire logic [3:0]         series_cells_i,
  input  wire logic [15:0]        empty_mv_i,
  input  wire logic [7:0]         health_gain_i,
  input  wire logic [7:0]         health_low_threshold_i,
  input  wire logic [15:0]        eol_trend_limit_i,
  input  wire logic [7:0]         alert_enable_i,
  output logic                    meas_req_o,
  output logic [15:0]             voltage_o,
  output logic signed [15:0]      temp_o,
  output logic signed [15:0]      die_sensor_reading_o,
  output logic signed [15:0]      current_o,
  output logic signed [31:0]      charge_o,
  output logic [15:0]             resistance_o,
  output logic signed [15:0]      resistance_rate_o,
  output logic [7:0]              health_percentage_o,
  output logic [7:0]              cell_condition_flags_o,
  output logic [7:0]              control_state_word_o,
  output logic [7:0]              alert_flags_latch_o,
  output logic                    alert_o
);
  pcg_state_t state_r, state_nxt;
  pcg_mode_t  mode_r, mode_nxt;
  logic        tsel_r, tsel_nxt, gate_q_r, pend_r, pend_nxt, req_r, req_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic [15:0] volt_r, volt_nxt, ocv_r, ocv_nxt, res_r, res_nxt;
  logic signed [15:0] temp_r, temp_nxt, die_r, die_nxt, cur_r, cur_nxt, rate_r, rate_nxt;
  logic signed [14:0] cc_last_r, cc_last_nxt;
  logic signed [31:0] charge_r, charge_nxt;
  logic [7:0]  health_r, health_nxt, cond_r, cond_nxt, alert_r, alert_nxt, ctrl_r, ctrl_nxt;
  logic [15:0] scaled_mv;
  logic [23:0] health_prod;
  logic [23:0] cell_avg;
  logic        tick_hit, conv_done, run;

  assign tick_hit  = (tick_r == MEAS_CYCLES - 1);
  assign run       = host_power_gate_pin_i && (state_r != PCG_OFF);
  assign conv_done = run && pend_r && meas_valid_i;

  always_comb begin
    // 24 bits hold the whole 16 x 8 product before the Q0.8 shift
    cell_avg  = 24'(cell_voltage_input_i) * 24'(cell_gain_i);
    scaled_mv = ext_scale_en_i ? 16'((cell_avg >> 8) * 24'(series_cells_i))
                               : cell_voltage_input_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt   = state_r;
    mode_nxt    = mode_r;
    tsel_nxt    = tsel_r;
    tick_nxt    = tick_r;
    req_nxt     = 1'b0;
    pend_nxt    = pend_r;
    volt_nxt    = volt_r;
    temp_nxt    = temp_r;
    die_nxt     = die_r;
    cur_nxt     = cur_r;
    ocv_nxt     = ocv_r;
    res_nxt     = res_r;
    rate_nxt    = rate_r;
    health_nxt  = health_r;
    cond_nxt    = cond_r;
    ctrl_nxt    = ctrl_r;
    cc_last_nxt = cc_last_r;
    charge_nxt  = charge_r;
    health_prod = 24'h00_0000;
    if (cc_valid_i) begin
      cc_last_nxt = cc_sample_i;
      charge_nxt  = charge_r + 32'(cc_sample_i);
    end
    if (req_r) pend_nxt = 1'b1;
    unique case (state_r)
      PCG_OFF: begin
        // mode and source latched once; later config changes are ignored
        mode_nxt = pcg_mode_t'(mode_cfg_i);
        tsel_nxt = temp_source_select_i;
        if (pcg_mode_t'(mode_cfg_i) == PCG_ACCUMULATE_MODE) begin
          state_nxt = PCG_ACC_WAIT;
        end else begin
          req_nxt   = 1'b1;
          state_nxt = (pcg_mode_t'(mode_cfg_i) == PCG_HEALTH_MODE) ? PCG_SOH_MEAS : PCG_EOL_RUN;
        end
      end
      PCG_ACC_WAIT: if (begin_accum_i) begin
        ctrl_nxt  = 8'h01 << `PCG_CTRL_ACT_BIT;
        tick_nxt  = 32'h0000_0000;
        state_nxt = PCG_ACC_RUN;
      end
      PCG_ACC_RUN: begin
        tick_nxt = tick_hit ? 32'h0000_0000 : tick_r + 32'h0000_0001;
        req_nxt  = tick_hit;
        if (end_accum_i) state_nxt = PCG_ACC_END;
      end
      PCG_ACC_END: if (!pend_r && !req_r) begin
        // wait out a conversion in flight so the last result is not lost
        ctrl_nxt  = 8'h01 << `PCG_CTRL_DONE_BIT;
        state_nxt = PCG_ACC_DONE;
      end
      PCG_EOL_RUN: begin
        tick_nxt = tick_hit ? 32'h0000_0000 : tick_r + 32'h0000_0001;
        req_nxt  = tick_hit;
      end
      PCG_SOH_MEAS: if (conv_done) state_nxt = PCG_SOH_DONE;
      PCG_ACC_DONE, PCG_SOH_DONE: ;
    endcase
    if (conv_done) begin
      // all results from one conversion move together
      // a request raised in this same cycle stays pending: set wins
      pend_nxt = req_r;
      volt_nxt = scaled_mv;
      temp_nxt = tsel_r ? ext_temp_raw_i : die_temp_raw_i;
      die_nxt  = die_temp_raw_i;
      cur_nxt  = 16'(32'(cc_last_r) - 32'(self_consumption_offset_i));
      if (mode_r == PCG_END_OF_LIFE_MODE) begin
        // first sample after gate-on is taken as the rested open-circuit level
        if (ocv_r == `PCG_WORD_RST) ocv_nxt = scaled_mv;
        res_nxt  = (ocv_nxt > scaled_mv) ? 16'(ocv_nxt - scaled_mv) : `PCG_WORD_RST;
        rate_nxt = 16'(res_nxt - res_r);
        health_prod = 24'(res_nxt) * 24'(health_gain_i);
        health_nxt  = (health_prod[23:8] >= 16'(`PCG_HEALTH_MAX)) ? 8'h00 :
                      8'(`PCG_HEALTH_MAX - health_prod[15:8]);
        cond_nxt[`PCG_COND_EOL_BIT] = (rate_nxt > $signed(eol_trend_limit_i));
      end else if (mode_r == PCG_HEALTH_MODE) begin
        health_prod = 24'(scaled_mv > empty_mv_i ? scaled_mv - empty_mv_i : 16'h0000) *
                      24'(health_gain_i);
        health_nxt  = (health_prod[23:8] >= 16'(`PCG_HEALTH_MAX)) ? `PCG_HEALTH_MAX :
                      health_prod[15:8];
      end
      cond_nxt[`PCG_COND_HLOW_BIT] = (health_nxt <= health_low_threshold_i);
    end
  end

  assign alert_nxt = alert_enable_i & cond_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= PCG_OFF;
      mode_r <= PCG_ACCUMULATE_MODE;
      {tsel_r, pend_r, req_r, gate_q_r} <= 4'h0;
      tick_r <= 32'h0000_0000;
      {volt_r, temp_r, die_r, cur_r, ocv_r, res_r, rate_r} <= 112'h0;
      {health_r, cond_r, ctrl_r, alert_r} <= 32'h0;
      cc_last_r <= 15'h0000;
      charge_r <= `PCG_CHARGE_RST;
    end else if (!host_power_gate_pin_i) begin
      // gate low powers the device down: everything except mode_r back to reset values
      state_r <= PCG_OFF;
      {tsel_r, pend_r, req_r, gate_q_r} <= 4'h0;
      tick_r <= 32'h0000_0000;
      {volt_r, temp_r, die_r, cur_r, ocv_r, res_r, rate_r} <= 112'h0;
      {health_r, cond_r, ctrl_r, alert_r} <= 32'h0;
      cc_last_r <= 15'h0000;
      charge_r <= `PCG_CHARGE_RST;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      tsel_r <= tsel_nxt;
      pend_r <= pend_nxt;
      req_r <= req_nxt;
      gate_q_r <= 1'b1;
      tick_r <= tick_nxt;
      {volt_r, temp_r, die_r, cur_r} <= {volt_nxt, temp_nxt, die_nxt, cur_nxt};
      {ocv_r, res_r, rate_r} <= {ocv_nxt, res_nxt, rate_nxt};
      {health_r, cond_r, ctrl_r, alert_r} <= {health_nxt, cond_nxt, ctrl_nxt, alert_nxt};
      cc_last_r <= cc_last_nxt;
      charge_r <= charge_nxt;
    end
  end

  assign meas_req_o             = req_r;
  assign voltage_o              = volt_r;
  assign temp_o                 = temp_r;
  assign die_sensor_reading_o   = die_r;
  assign current_o              = cur_r;
  assign charge_o               = charge_r;
  assign resistance_o           = res_r;
  assign resistance_rate_o      = rate_r;
  assign health_percentage_o    = health_r;
  assign cell_condition_flags_o = cond_r;
  assign control_state_word_o   = ctrl_r;
  assign alert_flags_latch_o    = alert_r;
  assign alert_o                = |alert_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i || !host_power_gate_pin_i);

  sequence acc_period_s;
    (state_r == PCG_ACC_RUN) && tick_hit && !end_accum_i;
  endsequence
  sequence gate_on_s;
    $rose(gate_q_r) && (mode_r != PCG_ACCUMULATE_MODE);
  endsequence

  acc_period_a: assert property (acc_period_s |=> meas_req_o)
    else $error("no measurement request at the one second mark");
  acc_quiet_a: assert property ((state_r == PCG_ACC_RUN) && !tick_hit |=> !meas_req_o)
    else $error("measurement requested off the one second mark");
  gate_meas_a: assert property (gate_on_s |-> meas_req_o)
    else $error("no measurement after gate rose");
  health_low_a: assert property (conv_done |=>
    cond_r[`PCG_COND_HLOW_BIT] == (health_r <= $past(health_low_threshold_i)))
    else $error("low-health flag disagrees with threshold");
  temp_src_a: assert property (conv_done |=>
    (temp_o == (tsel_r ? $past(ext_temp_raw_i) : $past(die_temp_raw_i)))
    && (die_sensor_reading_o == $past(die_temp_raw_i)))
    else $error("temperature source mixed up");
  cur_offset_a: assert property (conv_done |=>
    current_o == 16'($past(cc_last_r) - $past(self_consumption_offset_i)))
    else $error("current not offset corrected");
  charge_acc_a: assert property (cc_valid_i |=>
    charge_o == $past(charge_o) + 32'($past(cc_sample_i)))
    else $error("charge counter missed a sample");
  alert_gate_a: assert property (##1 alert_o == |($past(alert_enable_i) & $past(cond_r)))
    else $error("alert pin not gated by enables");
  mode_hold_a: assert property ((state_r != PCG_OFF) |=> $stable(mode_r))
    else $error("mode changed while powered");
  hold_result_a: assert property (!conv_done |=> $stable(voltage_o) && $stable(temp_o))
    else $error("result changed without a conversion");
endmodule

// ===== dv/pcg_conv_model.sv
// converter model that answers each conversion request after a chosen lag
`timescale 1ns/1ps
module pcg_conv_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       meas_req_i,
  input  wire logic [3:0] lag_i,
  output logic            meas_valid_o
);
  logic       busy_r;
  logic [3:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////////////
  // one result per request; a request while busy restarts the lag and drops the earlier result; never unprompted
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_r       <= 1'b0;
      cnt_r        <= 4'h0;
      meas_valid_o <= 1'b0;
    end else if (meas_req_i) begin
      busy_r       <= 1'b1;
      cnt_r        <= lag_i;
      meas_valid_o <= 1'b0;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r       <= 1'b0;
      meas_valid_o <= 1'b1;
    end else begin
      cnt_r        <= busy_r ? cnt_r - 4'h1 : cnt_r;
      meas_valid_o <= 1'b0;
    end
  end
endmodule

// ===== dv/test_primary_cell_gauge_sequencer.sv
// self-checking bench for the gauge sequencer in its three modes
`timescale 1ns/1ps
module test_primary_cell_gauge_sequencer;
  import pcg_pkg::*;
  localparam int unsigned MC = 20;
  logic               clk_i, reset_i, gate, src, beg, fin, mv, ccv, req, alert, done, xs;
  logic [1:0]         mode;
  logic [3:0]         lag, sc;
  logic [15:0]        volt, empty, lim, v_o, r_o;
  logic signed [15:0] dtemp, etemp, ofs, t_o, d_o, c_o, rr_o;
  logic signed [14:0] ccs;
  logic signed [31:0] q_o;
  logic [7:0]         hgain, hthr, aen, h_o, f_o, w_o, a_o, cg;
  int                 n_mismatch = 0;
  int                 comparisons = 0;
  int                 n;
  logic signed [14:0] smp [3] = '{-15'sd5, 15'sd100, 15'sd7};
  always_comb done = w_o[1];
  ////////////////////////////////////////////////////////////////////////////////
  pcg_sequencer #(.MEAS_CYCLES(MC)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .host_power_gate_pin_i(gate), .mode_cfg_i(mode),
    .temp_source_select_i(src), .begin_accum_i(beg), .end_accum_i(fin), .meas_valid_i(mv),
    .cell_voltage_input_i(volt), .die_temp_raw_i(dtemp), .ext_temp_raw_i(etemp),
    .cc_valid_i(ccv), .cc_sample_i(ccs), .self_consumption_offset_i(ofs),
    .ext_scale_en_i(xs), .cell_gain_i(cg), .series_cells_i(sc), .empty_mv_i(empty),
    .health_gain_i(hgain), .health_low_threshold_i(hthr), .eol_trend_limit_i(lim),
    .alert_enable_i(aen), .meas_req_o(req), .voltage_o(v_o), .temp_o(t_o),
    .die_sensor_reading_o(d_o), .current_o(c_o), .charge_o(q_o), .resistance_o(r_o),
    .resistance_rate_o(rr_o), .health_percentage_o(h_o), .cell_condition_flags_o(f_o),
    .control_state_word_o(w_o), .alert_flags_latch_o(a_o), .alert_o(alert));
  pcg_conv_model conv_model (
    .clk_i(clk_i), .reset_i(reset_i), .meas_req_i(req), .lag_i(lag), .meas_valid_o(mv));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // every wait is bounded; running out ends the run as a failure
  task automatic wait_hi(ref logic s, input int bound, output int k);
    for (k = 1; k <= bound; k++) begin
      @(posedge clk_i);
      #1;
      if (s === 1'b1) return;
    end
    check("wait bound", 32'h0, 32'h1);
    wrap_up();
  endtask
  task automatic power(logic [1:0] m, logic s);
    @(posedge clk_i);
    gate <= 1'b0;
    mode <= m;
    src  <= s;
    repeat (2) @(posedge clk_i);
    gate <= 1'b1;
  endtask
  task automatic result();
    wait_hi(mv, 20, n);
    @(posedge clk_i);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    {reset_i, gate, src, beg, fin, ccv, mode, lag} = {1'b1, 5'h00, 2'h0, 4'h0};
    {xs, cg, sc} = {1'b0, 8'h00, 4'h1};
    {volt, empty, lim, dtemp, etemp, ofs} = {16'h0BB8, 16'h07D0, 16'h0005, 16'h0BA4,
                                             16'h0B90, 16'h0010};
    {ccs, hgain, hthr, aen} = {15'h0000, 8'h10, 8'h3E, 8'h01};
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    // health session, external source, prompt converter
    power(2'h1, 1'b1);
    wait_hi(req, 3, n);
    check("request latency", n, 32'h1);
    result();
    check("voltage", v_o, 16'h0BB8);
    check("temperature", t_o[15:0], 16'h0B90);
    check("die reading", d_o[15:0], 16'h0BA4);
    check("health", h_o, 8'h3E);
    check("flags", f_o, 8'h01);
    @(posedge clk_i);
    #1;
    check("alert latch", a_o, 8'h01);
    check("alert pin", alert, 1'b1);
    // host reads health back before it drops the gate; the result must sit still
    repeat (2) @(posedge clk_i);
    #1;
    check("health kept", h_o, 8'h3E);
    $display("health test done");
    // accumulate session, die source, slow converter
    lag <= 4'h5;
    power(2'h0, 1'b0);
    repeat (2) @(posedge clk_i);
    beg <= 1'b1;
    @(posedge clk_i);
    beg <= 1'b0;
    #1;
    check("active word", w_o, 8'h01);
    foreach (smp[i]) begin
      @(posedge clk_i);
      ccv <= 1'b1;
      ccs <= smp[i];
    end
    @(posedge clk_i);
    ccv <= 1'b0;
    @(posedge clk_i);
    #1;
    check("charge", q_o, 32'h0000_0066);
    wait_hi(req, 2 * MC, n);
    wait_hi(req, 2 * MC, n);
    check("request period", n, MC);
    check("temperature", t_o[15:0], 16'h0BA4);
    check("current", c_o[15:0], 16'hFFF7);
    @(posedge clk_i);
    volt <= 16'h0BAE;
    fin  <= 1'b1;
    @(posedge clk_i);
    fin <= 1'b0;
    #1;
    // done must wait for the conversion still in flight
    check("word before done", w_o, 8'h01);
    wait_hi(done, 20, n);
    check("done word", w_o, 8'h02);
    check("last voltage", v_o, 16'h0BAE);
    $display("accumulate test done");
    // end-of-life session, mode input moved after power-up
    {lag, volt, hgain, hthr, aen} <= {4'h0, 16'h0BB8, 8'h80, 8'h00, 8'h02};
    power(2'h2, 1'b0);
    wait_hi(req, 4, n);
    check("eol request latency", n, 32'h1);
    // mode input moves once the session has latched its mode
    mode <= 2'h1;
    result();
    check("open resistance", r_o, 16'h0000);
    check("full health", h_o, 8'h64);
    @(posedge clk_i);
    volt <= 16'h0BAE;
    wait_hi(req, 2 * MC, n);
    result();
    check("resistance", r_o, 16'h000A);
    check("rate", rr_o[15:0], 16'h000A);
    check("eol health", h_o, 8'h5F);
    check("eol flags", f_o, 8'h02);
    @(posedge clk_i);
    #1;
    check("eol alert", a_o, 8'h02);
    $display("end-of-life test done");
    // health session behind an external divider: three cells, half gain
    {xs, cg, sc, volt} <= {1'b1, 8'h80, 4'h3, 16'h0400};
    power(2'h1, 1'b0);
    wait_hi(req, 3, n);
    check("scaled latency", n, 32'h1);
    result();
    check("scaled voltage", v_o, 16'h0600);
    check("empty health", h_o, 8'h00);
    check("empty flags", f_o, 8'h01);
    @(posedge clk_i);
    #1;
    check("masked alert", alert, 1'b0);
    $display("scaling test done");
    wrap_up();
  end
endmodule
